/* File: hw/rsc_defs.svh */
// register map, field positions, keys and timing counts of the rtc status block
// assumes a 40 MHz system clock and a 32 kHz reference tick pulse
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH
// byte offsets on the apb bus
`define RSC_OFF_CTRL     8'h40
`define RSC_OFF_STATUS   8'h44
`define RSC_OFF_IRQ_EN   8'h48
`define RSC_OFF_COMP_LO  8'h4C
`define RSC_OFF_COMP_HI  8'h50
`define RSC_OFF_KEY1     8'h6C
`define RSC_OFF_KEY2     8'h70
// status fields
`define RSC_ST_BUSY      0
`define RSC_ST_RUN       1
`define RSC_ST_SEC       2
`define RSC_ST_ALARM     6
`define RSC_ST_RSVD_VAL  25'h1FFFFFF
// irq enable fields
`define RSC_IE_ALARM     3
`define RSC_IE_TIMER     2
// control fields
`define RSC_CT_RUN       0
`define RSC_CT_AUTO      2
// unlock keys
`define RSC_KEY1_VAL     32'h83E70B13
`define RSC_KEY2_VAL     32'h95A4F1E0
// reset values
`define RSC_RST_BYTE     8'h00
`define RSC_RST_IE       4'h0
// timing
`define RSC_REF_TICKS    17'h08000
`define RSC_CLK_PERIOD_NS 25
`define RSC_BUSY_LEAD_NS  15000
`define RSC_REF_PERIOD_NS 30517
`define RSC_BUSY_LEAD_CYC ((`RSC_BUSY_LEAD_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_REF_CYC       (`RSC_REF_PERIOD_NS / `RSC_CLK_PERIOD_NS)
`define RSC_BUSY_START    11'(`RSC_REF_CYC - `RSC_BUSY_LEAD_CYC)
`endif

/* File: hw/rsc_pkg.sv */
// types shared by the rtc status block
// assumes nothing beyond the defs header
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_LOCKED  = 2'b00,
    RSC_KEY_ONE = 2'b01,
    RSC_OPEN    = 2'b10
  } rsc_lock_e;
  typedef enum logic [1:0] {
    RSC_EV_SEC  = 2'b00,
    RSC_EV_MIN  = 2'b01,
    RSC_EV_HOUR = 2'b10,
    RSC_EV_DAY  = 2'b11
  } rsc_period_e;
endpackage : rsc_pkg

/* File: hw/rsc_time_chain.sv */
// cascade of second, minute and hour counters giving advance pulses
// assumes sec_tick is a one-cycle pulse once per second
`timescale 1ns/1ps
module rsc_time_chain (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic sec_tick,
  output logic      min_adv,
  output logic      hr_adv,
  output logic      day_adv
);
  wire  [3:0] carry;

  // wrap limit of each stage
  function automatic logic [5:0] lim(input int unsigned idx);
    lim = (idx == 2) ? 6'h17 : 6'h3B;
  endfunction : lim

  assign carry[0] = sec_tick;

  ////////////////////////////////////////////////////////////////////////////
  // one counter per stage, carry out on wrap
  genvar i;
  for (i = 0; i < 3; i++) begin : g_stage
    logic [5:0] cnt_q;
    assign carry[i+1] = carry[i] & (cnt_q == lim(i));
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q <= 6'h00;
      end else if (ce && carry[i]) begin
        cnt_q <= carry[i+1] ? 6'h00 : cnt_q + 6'h01;
      end
    end
  end

  assign min_adv = carry[1];
  assign hr_adv  = carry[2];
  assign day_adv = carry[3];
endmodule : rsc_time_chain

/* File: hw/rsc_status_regs.sv */
// rtc status, interrupt enable, drift compensation and key protection over apb
// assumes ref_tick is a one-cycle 32 kHz pulse and alarm_match comes from the
// calendar compare logic, both synchronous to clk
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "rsc_defs.svh"

// Behaviour
// - alarm flag sets on alarm when enable bit 3 set, write-one clears
// - bit 5 shows day advance when timer on
// - bit 4 shows hour advance when timer on
// - bit 3 shows minute advance when timer on
// - bit 2 shows second advance when timer on
// - bit 1 reads one while counter runs
// - bit 0 busy during update and 15us before
// - enable bit 3 gates alarm interrupt, resets zero
// - enable bit 2 turns periodic interrupts on
// - bits 1-0 pick second, minute, hour, day
// - compensation bytes subtracted from 32k period
// - low compensation byte read/write, resets zero
// - compensation applies only with auto enable
// - protected registers ignore writes until unlocked
// - unlock needs first key then second key
// - any first key write re-locks
// - compensation applied once per hour
module rsc_status_regs
  import rsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ref_tick,
  input  wire logic        alarm_match,
  output logic             sec_pulse,
  output logic             irq
);
  rsc_lock_e   lock_q;
  rsc_lock_e   lock_d;
  logic        run_q;
  logic        auto_q;
  logic [3:0]  ie_q;
  logic [7:0]  comp_lo_q;
  logic [7:0]  comp_hi_q;
  logic [31:0] key1_q;
  logic [31:0] key2_q;
  logic        alarm_q;
  logic [3:0]  evt_q;
  logic [16:0] sub_q;
  logic [16:0] len_q;
  logic [16:0] len_d;
  logic [10:0] cyc_q;
  logic        irq_q;
  logic [31:0] prdata_q;
  logic        min_adv;
  logic        hr_adv;
  logic        day_adv;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // pick the advance pulse of the selected period
  function automatic logic pick_adv(input logic [1:0] sel, input logic [3:0] adv);
    case (rsc_period_e'(sel))
      RSC_EV_SEC:  pick_adv = adv[0];
      RSC_EV_MIN:  pick_adv = adv[1];
      RSC_EV_HOUR: pick_adv = adv[2];
      RSC_EV_DAY:  pick_adv = adv[3];
      default:     pick_adv = 1'b0;
    endcase
  endfunction : pick_adv

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire        wr_acc   = psel & penable & pwrite & ce;
  wire        setup    = psel & ~penable;
  wire        hit_ctrl = (paddr == `RSC_OFF_CTRL);
  wire        hit_st   = (paddr == `RSC_OFF_STATUS);
  wire        hit_ie   = (paddr == `RSC_OFF_IRQ_EN);
  wire        hit_clo  = (paddr == `RSC_OFF_COMP_LO);
  wire        hit_chi  = (paddr == `RSC_OFF_COMP_HI);
  wire        hit_k1   = (paddr == `RSC_OFF_KEY1);
  wire        hit_k2   = (paddr == `RSC_OFF_KEY2);
  wire        hit_any  = hit_ctrl | hit_st | hit_ie | hit_clo | hit_chi | hit_k1 | hit_k2;
  wire        unlocked = (lock_q == RSC_OPEN);
  wire        wr_prot  = wr_acc & unlocked;
  wire        wr_ctrl  = wr_prot & hit_ctrl;
  wire        wr_st    = wr_prot & hit_st;
  wire        wr_ie    = wr_prot & hit_ie;
  wire        wr_clo   = wr_prot & hit_clo;
  wire        wr_chi   = wr_prot & hit_chi;
  wire        wr_k1    = wr_acc & hit_k1;
  wire        wr_k2    = wr_acc & hit_k2;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata  = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // key sequence
  always_comb begin
    lock_d = lock_q;
    if (wr_k1) begin
      lock_d = (pwdata == `RSC_KEY1_VAL) ? RSC_KEY_ONE : RSC_LOCKED;
    end else if (wr_k2) begin
      lock_d = (lock_q == RSC_KEY_ONE && pwdata == `RSC_KEY2_VAL) ? RSC_OPEN
             : (lock_q == RSC_OPEN) ? RSC_OPEN : RSC_LOCKED;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= RSC_LOCKED;
      key1_q <= 32'h00000000;
      key2_q <= 32'h00000000;
    end else if (ce) begin
      lock_q <= lock_d;
      if (wr_k1) key1_q <= pwdata;
      if (wr_k2) key2_q <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, enable and compensation registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q     <= 1'b0;
      auto_q    <= 1'b0;
      ie_q      <= `RSC_RST_IE;
      comp_lo_q <= `RSC_RST_BYTE;
      comp_hi_q <= `RSC_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        run_q  <= pwdata[`RSC_CT_RUN];
        auto_q <= pwdata[`RSC_CT_AUTO];
      end
      if (wr_ie)  ie_q      <= pwdata[3:0];
      if (wr_clo) comp_lo_q <= pwdata[7:0];
      if (wr_chi) comp_hi_q <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 32 kHz divider with hourly compensation
  wire [15:0] comp_val = {comp_hi_q, comp_lo_q};
  wire        last_tk  = (sub_q == len_q - 17'h00001);
  wire        apply_c  = hr_adv & auto_q;
  assign sec_pulse = ce & run_q & ref_tick & last_tk;
  assign len_d     = apply_c ? (`RSC_REF_TICKS - {comp_val[15], comp_val})
                             : `RSC_REF_TICKS;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_q <= 17'h00000;
      len_q <= `RSC_REF_TICKS;
      cyc_q <= 11'h000;
    end else if (ce) begin
      if (ref_tick) begin
        cyc_q <= 11'h000;
      end else if (cyc_q != 11'h7FF) begin
        cyc_q <= cyc_q + 11'h001;
      end
      if (sec_pulse) begin
        sub_q <= 17'h00000;
        len_q <= len_d;
      end else if (run_q && ref_tick) begin
        sub_q <= sub_q + 17'h00001;
      end
    end
  end

  rsc_time_chain u_chain (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .sec_tick (sec_pulse),
    .min_adv  (min_adv),
    .hr_adv   (hr_adv),
    .day_adv  (day_adv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status flags and interrupt request
  wire [3:0] adv_now   = {day_adv, hr_adv, min_adv, sec_pulse};
  wire       tmr_en    = ie_q[`RSC_IE_TIMER];
  wire       alarm_set = ce & alarm_match & ie_q[`RSC_IE_ALARM];
  wire       alarm_clr = wr_st & pwdata[`RSC_ST_ALARM];
  wire       busy      = (run_q & last_tk & (cyc_q >= `RSC_BUSY_START)) | sec_pulse;
  wire [3:0] evt_vis   = evt_q & {4{tmr_en}};
  wire       per_hit   = tmr_en & pick_adv(ie_q[1:0], adv_now);
  wire [31:0] st_rd    = {`RSC_ST_RSVD_VAL, alarm_q, evt_vis, run_q, busy};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_q <= 1'b0;
      evt_q   <= 4'h0;
      irq_q   <= 1'b0;
    end else if (ce) begin
      if (alarm_set) alarm_q <= 1'b1;
      else if (alarm_clr) alarm_q <= 1'b0;
      if (sec_pulse) evt_q <= adv_now;
      irq_q <= alarm_set | per_hit;
    end
  end
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // read data captured in the setup cycle
  wire [31:0] rd_mux =
      hit_ctrl ? {29'h0, auto_q, 1'b0, run_q} :
      hit_st   ? st_rd :
      hit_ie   ? {28'h0, ie_q} :
      hit_clo  ? {24'h0, comp_lo_q} :
      hit_chi  ? {24'h0, comp_hi_q} :
      hit_k1   ? key1_q :
      hit_k2   ? key2_q : 32'h00000000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h00000000;
    end else if (ce && setup) begin
      prdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_alarm_set;
    alarm_set |=> alarm_q;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set");

  property p_alarm_clr;
    alarm_clr && !alarm_set |=> !alarm_q;
  endproperty
  a_alarm_clr: assert property (p_alarm_clr) else $error("alarm flag not cleared");

  property p_evt_mask;
    !tmr_en |-> st_rd[5:2] == 4'h0;
  endproperty
  a_evt_mask: assert property (p_evt_mask) else $error("event bits visible with timer off");

  property p_evt_sec;
    sec_pulse && tmr_en && !wr_ie |=> st_rd[`RSC_ST_SEC] && st_rd[3] == $past(min_adv);
  endproperty
  a_evt_sec: assert property (p_evt_sec) else $error("second event not shown");

  property p_run;
    st_rd[`RSC_ST_RUN] == run_q;
  endproperty
  a_run: assert property (p_run) else $error("run status wrong");

  property p_busy;
    sec_pulse |-> st_rd[`RSC_ST_BUSY];
  endproperty
  a_busy: assert property (p_busy) else $error("busy low during update");

  property p_locked;
    wr_acc && hit_ie && !unlocked |=> $stable(ie_q);
  endproperty
  a_locked: assert property (p_locked) else $error("write passed while locked");

  property p_relock;
    wr_k1 |=> lock_q != RSC_OPEN;
  endproperty
  a_relock: assert property (p_relock) else $error("first key write left unlocked");

  property p_unlock;
    wr_k2 && lock_q == RSC_KEY_ONE && pwdata == `RSC_KEY2_VAL |=> unlocked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("key sequence did not unlock");

  property p_bad_key2;
    wr_k2 && lock_q == RSC_KEY_ONE && pwdata != `RSC_KEY2_VAL |=> lock_q == RSC_LOCKED;
  endproperty
  a_bad_key2: assert property (p_bad_key2) else $error("wrong second key did not lock");

  property p_comp;
    sec_pulse && apply_c |=> len_q == `RSC_REF_TICKS - {$past(comp_hi_q[7]), $past(comp_val)};
  endproperty
  a_comp: assert property (p_comp) else $error("compensation not applied");

  property p_no_comp;
    sec_pulse && !apply_c |=> len_q == `RSC_REF_TICKS;
  endproperty
  a_no_comp: assert property (p_no_comp) else $error("compensation applied off the hour");

  property p_irq;
    ce && tmr_en && ie_q[1:0] == 2'h2 && hr_adv |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("hourly interrupt missing");

  property p_irq_sec;
    tmr_en && ie_q[1:0] == 2'h0 && sec_pulse |=> irq;
  endproperty
  a_irq_sec: assert property (p_irq_sec) else $error("per-second interrupt missing");
endmodule : rsc_status_regs

/* File: sim/rsc_status_regs_tb.sv */
// self-checking bench for the rtc status, enable, compensation and key registers
// assumes rsc_status_regs, rsc_pkg and rsc_defs.svh are compiled first
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_status_regs_tb;
  import rsc_pkg::*;
  localparam logic [7:0] a_st = `RSC_OFF_STATUS;
  localparam logic [7:0] a_ie = `RSC_OFF_IRQ_EN;
  localparam logic [7:0] a_lo = `RSC_OFF_COMP_LO;
  localparam logic [7:0] a_hi = `RSC_OFF_COMP_HI;
  localparam logic [7:0] a_ct = `RSC_OFF_CTRL;
  localparam logic [7:0] a_k1 = `RSC_OFF_KEY1;
  localparam logic [7:0] a_k2 = `RSC_OFF_KEY2;
  logic        clk, rst_n, ce, psel, penable, pwrite, ref_tick, alarm_match;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        pready, pslverr, sec_pulse, irq, err_q;
  int          fail_count, samples_checked, irq_cnt, sec_cnt, cyc, n;
  // reference model state
  logic        open_m, key1_m, alarm_m, run_m, busy_m;
  logic [3:0]  ie_m, ev_m;
  logic [7:0]  lo_m, hi_m;
  logic [7:0]  regs [4] = '{a_st, a_ie, a_lo, a_hi};

  rsc_status_regs dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_tick(ref_tick),
    .alarm_match(alarm_match), .sec_pulse(sec_pulse), .irq(irq)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // event counters and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (sec_pulse === 1'b1) sec_cnt <= sec_cnt + 1;
    if (cyc == 75000) begin
      fail_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // verdict, compare and bus tasks
  task test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_q  = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // bus write plus model update
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == a_k1) begin
      open_m = 1'b0;
      key1_m = (d == `RSC_KEY1_VAL);
    end else if (a == a_k2) begin
      open_m = open_m | (key1_m & (d == `RSC_KEY2_VAL));
      key1_m = 1'b0;
    end else if (open_m) begin
      case (a)
        a_ie: ie_m = d[3:0];
        a_lo: lo_m = d[7:0];
        a_hi: hi_m = d[7:0];
        a_ct: run_m = d[`RSC_CT_RUN];
        a_st: if (d[`RSC_ST_ALARM]) alarm_m = 1'b0;
        default: ;
      endcase
    end
  endtask : wr

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      a_st: return {`RSC_ST_RSVD_VAL, alarm_m, ie_m[2] ? ev_m : 4'h0, run_m, busy_m};
      a_ie: return {28'h0, ie_m};
      a_lo: return {24'h0, lo_m};
      a_hi: return {24'h0, hi_m};
      default: return 32'h0;
    endcase
  endfunction : exp_rd

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp_rd(a));
  endtask : rd

  task unlock();
    wr(a_k1, `RSC_KEY1_VAL);
    wr(a_k2, `RSC_KEY2_VAL);
  endtask : unlock

  // reference ticks held high for k consecutive cycles
  task ticks(input int k);
    repeat (k) begin
      @(posedge clk);
      ref_tick <= 1'b1;
    end
    @(posedge clk);
    ref_tick <= 1'b0;
    // let the event counters settle before anyone reads them
    repeat (2) @(posedge clk);
  endtask : ticks

  task alarm_try(input logic e);
    n = irq_cnt;
    @(posedge clk);
    alarm_match <= 1'b1;
    @(posedge clk);
    alarm_match <= 1'b0;
    repeat (3) @(posedge clk);
    alarm_m = alarm_m | e;
    chk(irq_cnt - n, {31'h0, e});
  endtask : alarm_try

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {psel, penable, pwrite, ref_tick, alarm_match, rst_n} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ce = 1'b1;
    {open_m, key1_m, alarm_m, run_m, busy_m, ie_m, ev_m, lo_m, hi_m} = '0;
    {fail_count, samples_checked, irq_cnt, sec_cnt, cyc} = '0;
    void'($urandom(32'h0c0b1a21));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (regs[i]) rd(regs[i]);
    wr(a_ie, 32'h0000000F);
    wr(a_lo, 32'h000000A5);
    rd(a_ie);
    rd(a_lo);
    // unmapped address answers with an error and zero data
    apb(1'b0, 8'h00, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    chk(rd_q, 32'h0);
    // bad second key, then second key alone, both stay locked
    wr(a_k1, `RSC_KEY1_VAL);
    wr(a_k2, 32'h0);
    wr(a_ie, 32'h3);
    rd(a_ie);
    wr(a_k2, `RSC_KEY2_VAL);
    wr(a_ie, 32'h3);
    rd(a_ie);
    unlock();
    // every period code and random compensation bytes
    for (int i = 0; i < 4; i++) begin
      wr(a_ie, ($urandom & 32'hFFFFFFF8) | i);
      rd(a_ie);
      wr(a_lo, $urandom);
      rd(a_lo);
      wr(a_hi, $urandom & 32'h3F);
      rd(a_hi);
    end
    // alarm gated, raised, then write-one clear
    wr(a_ie, 32'h0);
    alarm_try(1'b0);
    rd(a_st);
    wr(a_ie, 32'h8);
    alarm_try(1'b1);
    rd(a_st);
    wr(a_st, 32'hFFFFFFBF);
    rd(a_st);
    wr(a_st, 32'h40);
    rd(a_st);
    // any first key write relocks
    wr(a_k1, $urandom);
    wr(a_ie, 32'h7);
    rd(a_ie);
    unlock();
    // clock enable low drops a write
    ce <= 1'b0;
    apb(1'b1, a_lo, {24'h0, ~lo_m});
    ce <= 1'b1;
    rd(a_lo);
    // one second with minute period: no interrupt, second event seen
    wr(a_ct, 32'h1);
    wr(a_ie, 32'h5);
    rd(a_st);
    n = irq_cnt;
    ticks(32768);
    chk(sec_cnt, 1);
    chk(irq_cnt - n, 0);
    ev_m = 4'b0001;
    rd(a_st);
    // second period: busy lead before the final tick
    wr(a_ie, 32'h4);
    ticks(32767);
    chk(sec_cnt, 1);
    rd(a_st);
    repeat (700) @(posedge clk);
    busy_m = 1'b1;
    rd(a_st);
    n = irq_cnt;
    ticks(1);
    busy_m = 1'b0;
    repeat (3) @(posedge clk);
    chk(sec_cnt, 2);
    chk(irq_cnt - n, 1);
    rd(a_st);
    wr(a_ie, 32'h0);
    rd(a_st);
    wr(a_ct, 32'h0);
    rd(a_st);
    test_done();
  end
endmodule : rsc_status_regs_tb
